// ---- core/spbs_defs.svh ----
// constants of the pipelined burst sram port
`ifndef SPBS_DEFS_SVH
`define SPBS_DEFS_SVH
// ==========================================================
// organisation
`define SPBS_ADDR_W 19
`define SPBS_DATA_W 36
`define SPBS_LANES 4
`define SPBS_CNT_W 2
// ==========================================================
// test port
`define SPBS_IR_W 2
`define SPBS_DR_W 32
`define SPBS_IR_CAPTURE 2'h1
`define SPBS_IR_IDCODE 2'h1
`define SPBS_IR_BYPASS 2'h3
// arbitrary identity value
`define SPBS_IDCODE 32'h00000001
// ==========================================================
// pin synchroniser bit positions
`define SPBS_PIN_SLEEP 0
`define SPBS_PIN_MODE 1
`define SPBS_PIN_TCK 2
`define SPBS_PIN_TMS 3
`define SPBS_PIN_TDI 4
`define SPBS_PIN_N 5
`endif

// ---- core/spbs_pkg.sv ----
// types of the pipelined burst sram port
package spbs_pkg;
    // ==========================================================
    // operation carried down the pipeline
    typedef enum logic [1:0] {
        OP_IDLE = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h2
    } spbs_op_t;
    // ==========================================================
    // test access port controller
    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001,
        TAP_IDLE = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SH_DR = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PA_DR = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UP_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SH_IR = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PA_IR = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UP_IR = 16'h8000
    } spbs_tap_t;
endpackage

// ---- core/spbs_sram_port.sv ----
// pipelined burst sram port with zero turnaround and test port
// Function
// R1: all synchronous inputs are captured into input registers on the rising edge.
// R2: read data leaves from output registers loaded on the rising edge.
// R3: clock qualifier high makes an edge count for nothing; state holds.
// R4: reads and writes mix on consecutive cycles with no wait state.
// R5: write strobe requests a write; only selected byte lanes change.
// R6: array write completes internally from registered data, no pulse needed.
// R7: selected only when first and third selects low, second high.
// R8: output enable inactive three-states the data bus, with no clock.
// R9: data drivers are off during the data cycle of every write.
// R10: drivers turn around by internal timing, no output enable toggling.
// R11: bursts step addresses in linear or interleaved order.
// R12: sleep request deselects and parks the port; stopped clock is tolerated.
// R13: a boundary-scan test access port is provided.
// R14: read data stands on the bus two edges after address acceptance.
// R15: load low loads a new address, high steps the two-bit counter.
// R16: controller drives write data in the slot where read data would be.
//
// The address map and strobed register access were left to the implementer.
`include "spbs_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module spbs_sram_port #(
    parameter int ADDR_W = `SPBS_ADDR_W,
    parameter int DATA_W = `SPBS_DATA_W,
    parameter int LANES = `SPBS_LANES,
    parameter logic [`SPBS_DR_W-1:0] IDCODE_VALUE = `SPBS_IDCODE
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // synchronous controls
    input wire logic [ADDR_W-1:0] address,
    input wire logic writeEnable_n,
    input wire logic [LANES-1:0] byteLaneWriteSelect_n,
    input wire logic chipSelectFirst_n,
    input wire logic chipSelectSecond,
    input wire logic chipSelectThird_n,
    input wire logic burstStepOrLoad,
    input wire logic clockQualifier_n,
    // static and asynchronous controls
    input wire logic burstModeLinear,
    input wire logic sleepRequest,
    input wire logic outputEnable_n,
    // data bus, lane top bit is the extra lane bit
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    // test access port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOe
);
    localparam int LANE_W = DATA_W / LANES;
    localparam int CW = `SPBS_CNT_W;
    localparam int PN = `SPBS_PIN_N;

    // ==========================================================
    // state
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] bwN;
        logic weN;
        logic sel;
        logic adv;
    } spbs_in_t;

    typedef struct packed {
        spbs_pkg::spbs_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] bwN;
    } spbs_stage_t;

    typedef struct packed {
        logic [PN-1:0] syncA;
        logic [PN-1:0] syncB;
        logic [PN-1:0] syncC;
        logic [PN-1:0] lvl;
        spbs_in_t inp;
        logic [ADDR_W-1:0] base;
        logic [CW-1:0] cnt;
        spbs_pkg::spbs_op_t lastOp;
        spbs_stage_t s1;
        spbs_stage_t s2;
        spbs_stage_t s3;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic drive;
        spbs_pkg::spbs_tap_t tap;
        logic [`SPBS_IR_W-1:0] ir;
        logic [`SPBS_IR_W-1:0] irSh;
        logic [`SPBS_DR_W-1:0] dr;
        logic tdoBit;
        logic tdoEn;
    } spbs_state_t;

    spbs_state_t st_q;
    spbs_state_t st_d;
    logic [DATA_W-1:0] mem [2**ADDR_W];

    // ==========================================================
    // helpers
    function automatic logic [DATA_W-1:0] laneMerge(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] upd,
        input logic [LANES-1:0] bwN
    );
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < LANES; i++) begin
            if (!bwN[i]) begin
                r[i*LANE_W +: LANE_W] = upd[i*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction

    function automatic logic [CW-1:0] burstLow(
        input logic [CW-1:0] start,
        input logic [CW-1:0] n,
        input logic linear
    );
        return linear ? CW'(start + n) : (start ^ n);
    endfunction

    // ==========================================================
    // next state
    logic ce;
    logic tckRise;
    logic tckFall;
    logic [CW-1:0] cntNext;
    logic [DATA_W-1:0] rd;

    always_comb begin
        st_d = st_q;
        cntNext = CW'(st_q.cnt + 1'b1);
        rd = mem[st_q.s1.addr];
        // pin synchronisers; a change counts once second and third agree
        st_d.syncA = {tdi, tms, tck, burstModeLinear, sleepRequest};
        st_d.syncB = st_q.syncA;
        st_d.syncC = st_q.syncB;
        st_d.lvl = (st_q.syncB & st_q.syncC) | (st_q.lvl & (st_q.syncB | st_q.syncC));
        tckRise = st_d.lvl[`SPBS_PIN_TCK] & ~st_q.lvl[`SPBS_PIN_TCK];
        tckFall = ~st_d.lvl[`SPBS_PIN_TCK] & st_q.lvl[`SPBS_PIN_TCK];
        // qualified edge: whole pipeline waits while high
        ce = ~clockQualifier_n; // R3
        if (ce) begin
            // input registers
            st_d.inp.addr = address; // R1
            st_d.inp.bwN = byteLaneWriteSelect_n;
            st_d.inp.weN = writeEnable_n;
            st_d.inp.sel = ~chipSelectFirst_n & chipSelectSecond & ~chipSelectThird_n; // R7
            st_d.inp.adv = burstStepOrLoad;
            // sleep parks the port as a deselect
            if (st_q.lvl[`SPBS_PIN_SLEEP]) begin
                st_d.inp.sel = 1'b0; // R12
                st_d.inp.adv = 1'b0;
            end
            // burst stage
            st_d.s1.bwN = st_q.inp.bwN;
            if (st_q.inp.adv) begin
                st_d.cnt = cntNext; // R15
                st_d.s1.op = st_q.lastOp;
                st_d.s1.addr = {st_q.base[ADDR_W-1:CW],
                    burstLow(st_q.base[CW-1:0], cntNext, st_q.lvl[`SPBS_PIN_MODE])}; // R11
            end else if (st_q.inp.sel) begin
                st_d.base = st_q.inp.addr; // R15
                st_d.cnt = '0;
                st_d.s1.addr = st_q.inp.addr;
                st_d.s1.op = st_q.inp.weN ? spbs_pkg::OP_READ : spbs_pkg::OP_WRITE; // R5
            end else begin
                st_d.s1.op = spbs_pkg::OP_IDLE;
            end
            st_d.lastOp = st_d.s1.op;
            // read into output register, newest pending write wins
            if (st_q.s3.op == spbs_pkg::OP_WRITE && st_q.s3.addr == st_q.s1.addr) begin
                rd = laneMerge(rd, st_q.wdata, st_q.s3.bwN); // R4
            end
            if (st_q.s2.op == spbs_pkg::OP_WRITE && st_q.s2.addr == st_q.s1.addr) begin
                rd = laneMerge(rd, dataIn, st_q.s2.bwN); // R4
            end
            st_d.s2 = st_q.s1;
            st_d.drive = st_q.s1.op == spbs_pkg::OP_READ; // R9 R10
            if (st_q.s1.op == spbs_pkg::OP_READ) begin
                st_d.rdata = rd; // R2 R14
            end
            // write data sampled in the read data slot
            st_d.s3 = st_q.s2; // R16
            st_d.wdata = dataIn; // R1
        end
        // test access port, stepped on the filtered tck edges
        if (tckRise) begin
            case (st_q.tap)
                spbs_pkg::TAP_CAP_DR: begin
                    st_d.dr = (st_q.ir == `SPBS_IR_IDCODE) ? IDCODE_VALUE : '0; // R13
                end
                spbs_pkg::TAP_SH_DR: begin
                    if (st_q.ir == `SPBS_IR_IDCODE) begin
                        st_d.dr = {st_q.lvl[`SPBS_PIN_TDI], st_q.dr[`SPBS_DR_W-1:1]};
                    end else begin
                        st_d.dr[0] = st_q.lvl[`SPBS_PIN_TDI];
                    end
                end
                spbs_pkg::TAP_CAP_IR: begin
                    st_d.irSh = `SPBS_IR_CAPTURE;
                end
                spbs_pkg::TAP_SH_IR: begin
                    st_d.irSh = {st_q.lvl[`SPBS_PIN_TDI], st_q.irSh[`SPBS_IR_W-1:1]};
                end
                spbs_pkg::TAP_UP_IR: begin
                    st_d.ir = st_q.irSh;
                end
                spbs_pkg::TAP_RESET: begin
                    st_d.ir = `SPBS_IR_IDCODE;
                end
                default: begin
                end
            endcase
            st_d.tap = tapNext(st_q.tap, st_q.lvl[`SPBS_PIN_TMS]); // R13
        end
        // test output changes on the falling edge
        if (tckFall) begin
            st_d.tdoBit = (st_q.tap == spbs_pkg::TAP_SH_IR) ? st_q.irSh[0] : st_q.dr[0];
            st_d.tdoEn = st_q.tap == spbs_pkg::TAP_SH_IR || st_q.tap == spbs_pkg::TAP_SH_DR;
        end
    end

    function automatic spbs_pkg::spbs_tap_t tapNext(
        input spbs_pkg::spbs_tap_t s,
        input logic m
    );
        case (s)
            spbs_pkg::TAP_RESET: return m ? spbs_pkg::TAP_RESET : spbs_pkg::TAP_IDLE;
            spbs_pkg::TAP_IDLE: return m ? spbs_pkg::TAP_SEL_DR : spbs_pkg::TAP_IDLE;
            spbs_pkg::TAP_SEL_DR: return m ? spbs_pkg::TAP_SEL_IR : spbs_pkg::TAP_CAP_DR;
            spbs_pkg::TAP_CAP_DR: return m ? spbs_pkg::TAP_EX1_DR : spbs_pkg::TAP_SH_DR;
            spbs_pkg::TAP_SH_DR: return m ? spbs_pkg::TAP_EX1_DR : spbs_pkg::TAP_SH_DR;
            spbs_pkg::TAP_EX1_DR: return m ? spbs_pkg::TAP_UP_DR : spbs_pkg::TAP_PA_DR;
            spbs_pkg::TAP_PA_DR: return m ? spbs_pkg::TAP_EX2_DR : spbs_pkg::TAP_PA_DR;
            spbs_pkg::TAP_EX2_DR: return m ? spbs_pkg::TAP_UP_DR : spbs_pkg::TAP_SH_DR;
            spbs_pkg::TAP_UP_DR: return m ? spbs_pkg::TAP_SEL_DR : spbs_pkg::TAP_IDLE;
            spbs_pkg::TAP_SEL_IR: return m ? spbs_pkg::TAP_RESET : spbs_pkg::TAP_CAP_IR;
            spbs_pkg::TAP_CAP_IR: return m ? spbs_pkg::TAP_EX1_IR : spbs_pkg::TAP_SH_IR;
            spbs_pkg::TAP_SH_IR: return m ? spbs_pkg::TAP_EX1_IR : spbs_pkg::TAP_SH_IR;
            spbs_pkg::TAP_EX1_IR: return m ? spbs_pkg::TAP_UP_IR : spbs_pkg::TAP_PA_IR;
            spbs_pkg::TAP_PA_IR: return m ? spbs_pkg::TAP_EX2_IR : spbs_pkg::TAP_PA_IR;
            spbs_pkg::TAP_EX2_IR: return m ? spbs_pkg::TAP_UP_IR : spbs_pkg::TAP_SH_IR;
            spbs_pkg::TAP_UP_IR: return m ? spbs_pkg::TAP_SEL_DR : spbs_pkg::TAP_IDLE;
            default: return spbs_pkg::TAP_RESET;
        endcase
    endfunction

    // ==========================================================
    // registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
            st_q.s1.op <= spbs_pkg::OP_IDLE;
            st_q.s2.op <= spbs_pkg::OP_IDLE;
            st_q.s3.op <= spbs_pkg::OP_IDLE;
            st_q.lastOp <= spbs_pkg::OP_IDLE;
            st_q.tap <= spbs_pkg::TAP_RESET;
            st_q.ir <= `SPBS_IR_IDCODE;
        end else begin
            st_q <= st_d;
        end
    end

    // array write from registered data, lane by lane; no reset, contents
    // survive sleep and a stopped clock
    always_ff @(posedge mclk) begin
        if (!rst && !clockQualifier_n && st_q.s3.op == spbs_pkg::OP_WRITE) begin
            mem[st_q.s3.addr] <= laneMerge(mem[st_q.s3.addr], st_q.wdata, st_q.s3.bwN); // R5 R6
        end
    end

    // ==========================================================
    // outputs; enable gating is combinational so it works with no clock
    assign dataOut = st_q.rdata; // R2
    assign dataOe = st_q.drive & ~outputEnable_n & ~st_q.lvl[`SPBS_PIN_SLEEP]; // R8 R12
    assign tdo = st_q.tdoBit;
    assign tdoOe = st_q.tdoEn;
endmodule
`default_nettype wire

// ---- verif/spbs_sram_port_props.sv ----
// assertions on the pins of the pipelined burst sram port
`timescale 1ns/10ps
`default_nettype none
module spbs_sram_port_props #(
    parameter int DATA_W = 36
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // controls
    input wire logic writeEnable_n,
    input wire logic chipSelectFirst_n,
    input wire logic chipSelectSecond,
    input wire logic chipSelectThird_n,
    input wire logic burstStepOrLoad,
    input wire logic clockQualifier_n,
    input wire logic sleepRequest,
    input wire logic outputEnable_n,
    // outputs
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOe,
    input wire logic tdoOe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic sel;
    logic load;
    assign sel = !chipSelectFirst_n && chipSelectSecond && !chipSelectThird_n;
    assign load = !clockQualifier_n && !burstStepOrLoad && !sleepRequest;
    // ==========================================================
    // bus drive
    chk_oe_async: assert property (outputEnable_n |-> !dataOe)
        else $error("bus driven with output enable off");
    // sleep passes three sync flops plus the agree stage, so five samples are safe
    chk_sleep_off: assert property (sleepRequest [*5] |-> !dataOe)
        else $error("bus driven in sleep");
    chk_read_drive: assert property (!sleepRequest [*5] ##0 (sel && load && writeEnable_n)
        ##1 !clockQualifier_n [*2] |=> dataOe || outputEnable_n)
        else $error("read data not driven two edges on");
    chk_write_hiz: assert property (sel && load && !writeEnable_n
        ##1 !clockQualifier_n [*2] |=> !dataOe)
        else $error("bus driven in write data slot");
    chk_deselect_idle: assert property (!sel && load ##1 !clockQualifier_n [*2] |=> !dataOe)
        else $error("bus driven after deselect");
    // ==========================================================
    // registers
    chk_freeze_hold: assert property (clockQualifier_n && !rst |=> $stable(dataOut))
        else $error("read data moved on a qualified-off edge");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !dataOe && dataOut == '0 && !tdoOe)
        else $error("outputs not quiet in reset");
    chk_data_steps: assert property (!$stable(dataOut) |-> $past(!clockQualifier_n) || $past(rst))
        else $error("read data changed without an enabled edge");
endmodule
bind spbs_sram_port spbs_sram_port_props #(.DATA_W(DATA_W)) chk (
    .mclk(mclk), .rst(rst), .writeEnable_n(writeEnable_n),
    .chipSelectFirst_n(chipSelectFirst_n), .chipSelectSecond(chipSelectSecond),
    .chipSelectThird_n(chipSelectThird_n), .burstStepOrLoad(burstStepOrLoad),
    .clockQualifier_n(clockQualifier_n), .sleepRequest(sleepRequest),
    .outputEnable_n(outputEnable_n), .dataOut(dataOut), .dataOe(dataOe), .tdoOe(tdoOe)
);
`default_nettype wire

// ---- verif/spbs_ctrl_model.sv ----
// controller-side model that drives write data into its bus slot
`timescale 1ns/10ps
`default_nettype none
module spbs_ctrl_model (
    // clock and qualifier
    input wire logic mclk,
    input wire logic clockQualifier_n,
    // write requests from the bench
    input wire logic issueWrite,
    input wire logic [35:0] writeData,
    // device side of the bus
    input wire logic [35:0] dataOut,
    input wire logic dataOe,
    output logic [35:0] busLevel
);
    logic [36:0] s1 = '0, s2 = '0, s3 = '0;
    logic [35:0] last = '0;
    always @(posedge mclk) begin
        if (!clockQualifier_n) begin
            s1 <= {issueWrite, writeData};
            s2 <= s1;
            s3 <= s2;
        end
        last <= busLevel;
    end
    // no keeper on the bus: a released bus toggles, never looks valid
    assign busLevel = dataOe ? dataOut : s3[36] ? s3[35:0] : ~last;
endmodule
`default_nettype wire

// ---- verif/spbs_sram_port_tb.sv ----
// self-checking testbench of the pipelined burst sram port
`timescale 1ns/10ps
`default_nettype none
`include "spbs_defs.svh"
module spbs_sram_port_tb;
    localparam logic [2:0] SEL = 3'b010;
    localparam logic [2:0] OFF = 3'b111;
    logic mclk = 1'b0, rst = 1'b1, weN = 1'b1, cs1N = 1'b1, cs2 = 1'b0, cs3N = 1'b1;
    logic stepLd = 1'b0, cqN = 1'b0, lin = 1'b1, sleep = 1'b0, oeN = 1'b0, issueWr = 1'b0;
    logic [18:0] addr = '0, base = '0;
    logic [3:0] bwN = 4'hf;
    logic [35:0] wrData = '0, dOut, bus;
    logic dOe, tdo, tdoOe, asleep = 1'b0;
    logic tck = 1'b0, tms = 1'b0, tdi = 1'b0, tapOut, tapEn;
    logic [31:0] idShift = '0;
    logic [1:0] beat = '0;
    logic [37:0] cur = '0, p1 = '0, p2 = '0, p3 = '0;
    logic [35:0] mem [int];
    int bad_count = 0, comparisons = 0, cycles = 0;
    always #5 mclk = ~mclk;
    spbs_sram_port dut (.mclk(mclk), .rst(rst), .address(addr), .writeEnable_n(weN),
        .byteLaneWriteSelect_n(bwN), .chipSelectFirst_n(cs1N), .chipSelectSecond(cs2),
        .chipSelectThird_n(cs3N), .burstStepOrLoad(stepLd), .clockQualifier_n(cqN),
        .burstModeLinear(lin), .sleepRequest(sleep), .outputEnable_n(oeN), .dataIn(bus),
        .dataOut(dOut), .dataOe(dOe), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe(tdoOe));
    spbs_ctrl_model ctrl (.mclk(mclk), .clockQualifier_n(cqN), .issueWrite(issueWr),
        .writeData(wrData), .dataOut(dOut), .dataOe(dOe), .busLevel(bus));
    // ==========================================================
    // tasks
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // expected word worked out at issue, so reads after writes see them
    task automatic op(input logic we, input logic [2:0] cs, input logic [18:0] a,
                      input logic [35:0] d, input logic [3:0] b, input logic burst);
        logic [18:0] e;
        logic [35:0] m;
        logic sel;
        @(posedge mclk);
        sel = cs == SEL && !asleep;
        base = burst ? base : a;
        beat = burst ? beat + 2'h1 : 2'h0;
        e = {base[18:2], lin ? base[1:0] + beat : base[1:0] ^ beat};
        m = mem.exists(e) ? mem[e] : 36'h0;
        for (int i = 0; i < 4; i++) if (!b[i] && !we) m[9*i +: 9] = d[9*i +: 9];
        if (sel && !we) mem[e] = m;
        cur <= !sel ? 38'h0 : we ? {2'h1, m} : {2'h2, d};
        issueWr <= sel && !we;
        {addr, weN, bwN, cs1N, cs2, cs3N, stepLd, wrData, cqN} <= {a, we, b, cs, burst, d, 1'b0};
    endtask
    task automatic idle(input int n);
        repeat (n) op(1'b1, OFF, 19'h0, 36'h0, 4'hf, 1'b0);
    endtask
    // one slow test clock period; tms set a phase ahead so the filtered rise sees it
    task automatic tapBit(input logic m, output logic t, output logic en);
        @(posedge mclk);
        tck <= 1'b0;
        tms <= m;
        repeat (6) @(posedge mclk);
        t = tdo;
        en = tdoOe;
        tck <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask
    task automatic stall(input int n);
        @(posedge mclk);
        cqN <= 1'b1;
        repeat (n - 1) @(posedge mclk);
    endtask
    // ==========================================================
    // pipeline of expectations, shifted on enabled edges only
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles > 2000) begin
            bad_count++;
            stop_test();
        end
        if (rst) {p1, p2, p3} <= '0;
        else if (!cqN) {p1, p2, p3} <= {cur, p1, p2};
    end
    always @(negedge mclk) if (!rst) begin
        if (p3[37:36] == 2'h1) check(dOut, p3[35:0]);
        check({35'h0, dOe}, {35'h0, p3[37:36] == 2'h1 && !oeN});
    end
    // ==========================================================
    // scenarios
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check({34'h0, tdo, tdoOe}, 36'h0);
        check(dOut, 36'h0);
        for (int i = 0; i < 8; i++) op(i[0], SEL, 19'(32 + i / 2), {4'h5, 32'(i * 3)}, 4'h0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            op(1'b0, SEL, 19'h20, 36'hfffffffff, ~(4'h1 << k), 1'b0);
            op(1'b1, SEL, 19'h20, 36'h0, 4'hf, 1'b0);
        end
        for (int k = 0; k < 3; k++) begin
            op(1'b0, SEL ^ 3'(1 << k), 19'h21, 36'h0, 4'h0, 1'b0);
            op(1'b1, SEL, 19'h21, 36'h0, 4'hf, 1'b0);
        end
        op(1'b1, SEL, 19'h20, 36'h0, 4'hf, 1'b0);
        stall(3);
        op(1'b1, SEL, 19'h21, 36'h0, 4'hf, 1'b0);
        oeN <= 1'b1;
        op(1'b0, SEL, 19'h22, 36'h0abcdef12, 4'h0, 1'b0);
        stall(1);
        op(1'b1, SEL, 19'h22, 36'h0, 4'hf, 1'b0);
        idle(3);
        oeN <= 1'b0;
        for (int n = 0; n < 4; n++) op(1'b0, SEL, 19'h12, {4'h0, 32'(n * 7 + 1)}, 4'h0, n > 0);
        idle(1);
        lin <= 1'b0;
        idle(4);
        for (int n = 0; n < 4; n++) op(1'b1, SEL, 19'h11, 36'h0, 4'hf, n > 0);
        idle(3);
        sleep <= 1'b1;
        idle(5);
        asleep = 1'b1;
        op(1'b0, SEL, 19'h20, 36'h0, 4'h0, 1'b0);
        idle(1);
        sleep <= 1'b0;
        idle(5);
        asleep = 1'b0;
        op(1'b1, SEL, 19'h20, 36'h0, 4'hf, 1'b0);
        idle(3);
        // reset state holds the identity instruction: idle, select, capture, shift
        for (int n = 0; n < 36; n++) begin
            tapBit(n == 1, tapOut, tapEn);
            if (n > 3) idShift = {tapOut, idShift[31:1]};
        end
        check({4'h0, idShift}, {4'h0, `SPBS_IDCODE});
        check({35'h0, tapEn}, 36'h1);
        stop_test();
    end
endmodule
`default_nettype wire
